// ---- sbsm_pkg.sv ----
/*
  Package for the serial buffer status and mode block: register offsets,
  field positions and values after reset.
  Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
*/
`default_nettype none

package sbsm_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [31:0] ADDR_DATA       = 32'h0000_0000;
  localparam logic [31:0] ADDR_MODE       = 32'h0000_0004;
  localparam int          ADDR_WORD_LSB   = 2;
  localparam int          ADDR_DEC_MSB    = 11;

  // ----------------------------------------------------------------------
  // Mode and status register fields
  // ----------------------------------------------------------------------
  localparam int          POS_TX_EMPTY    = 7;
  localparam int          POS_RX_FULL     = 6;
  localparam int          POS_TX_RUN      = 5;
  localparam int          POS_STOP_TWO    = 4;
  localparam int          POS_BIT_ORDER   = 3;
  localparam int          POS_DBUF_EN     = 2;

  // ----------------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------------
  localparam logic        RST_TX_EMPTY    = 1'b1;
  localparam logic        RST_RX_FULL     = 1'b0;
  localparam logic        RST_TX_RUN      = 1'b0;
  localparam logic        RST_STOP_TWO    = 1'b0;
  localparam logic        RST_BIT_ORDER   = 1'b0;
  localparam logic        RST_DBUF_EN     = 1'b0;
  localparam logic [31:0] RST_WORD        = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // AHB-Lite encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic        HRESP_OKAY      = 1'b0;

endpackage

`default_nettype wire

// ---- sbsm_flags.sv ----
/*
  Buffer status flags of the serial channel: transmit buffer empty,
  receive buffer full and transmission running.
  Assumes all strobes are one-cycle pulses on core_clk from same-clock logic.
*/
`timescale 1ns/1ps
`default_nettype none

module sbsm_flags (
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic rx_load,
  input  wire logic status_read,
  input  wire logic tx_write,
  input  wire logic tx_load,
  input  wire logic tx_busy,
  output var  logic tx_empty,
  output var  logic rx_full,
  output var  logic tx_run
);

  logic next_tx_empty;
  logic next_rx_full;
  logic next_tx_run;

  // ----------------------------------------------------------------------
  // Flag update, hardware set wins over software clear
  // ----------------------------------------------------------------------
  always_comb begin
    next_rx_full = rx_full;
    if (status_read) begin
      next_rx_full = 1'b0;
    end
    if (rx_load) begin
      next_rx_full = 1'b1;
    end
    next_tx_empty = tx_empty;
    if (tx_write) begin
      next_tx_empty = 1'b0;
    end
    if (tx_load) begin
      next_tx_empty = 1'b1;
    end
    next_tx_run = tx_busy;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_empty <= sbsm_pkg::RST_TX_EMPTY;
      rx_full  <= sbsm_pkg::RST_RX_FULL;
      tx_run   <= sbsm_pkg::RST_TX_RUN;
    end else begin
      tx_empty <= next_tx_empty;
      rx_full  <= next_rx_full;
      tx_run   <= next_tx_run;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  rx_set_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    rx_load |=> rx_full)
    else $error("rx full flag not set after receive load");

  rx_clear_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    status_read && !rx_load |=> !rx_full)
    else $error("rx full flag not cleared by status read");

  rx_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !status_read && !rx_load |=> $stable(rx_full))
    else $error("rx full flag changed without cause");

  tx_clear_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    tx_write && !tx_load |=> !tx_empty)
    else $error("tx empty flag not cleared by buffer write");

  tx_set_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    tx_load |=> tx_empty)
    else $error("tx empty flag not set after shift load");

  tx_run_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    tx_busy ##1 !tx_busy |-> tx_run ##1 !tx_run)
    else $error("running flag does not follow transmitter");

endmodule

`default_nettype wire

// ---- sbsm_top.sv ----
/*
  Status and mode control of a serial channel running as UART or as a
  clocked I/O interface, with an AHB-Lite register slave.
  Assumes the shift-register datapath runs on core_clk and gives one-cycle
  buffer-move strobes and a busy level; no synchronisers are needed.
*/
// Design decisions made here: the AHB-Lite slave port and the address map.
// Operation
// - A received word moved into the receive buffer sets the receive-buffer-full flag.
// - Reading the status register clears the receive-buffer-full flag.
// - With double buffering off the buffer flags mean nothing to software.
// - Writing a word into the transmit buffer clears the transmit-buffer-empty flag.
// - A read-only running flag shows 1 while transmitting and 0 when stopped.
// - Running 1 is sending, running 0 with empty 1 is done, both 0 is waiting with a word.
// - In UART mode the stop-length bit picks one stop bit at 0 and two at 1.
// - The receiver checks a single stop bit whatever the stop-length bit says.
// - In I/O mode the bit-order bit picks LSB first at 0 and MSB first at 1.
// - The double-buffer enable turns the buffering stage off at 0 and on at 1.
// - A word moved from the transmit buffer to the shifter sets the transmit-buffer-empty flag.
`timescale 1ns/1ps
`default_nettype none

module sbsm_top (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  // Datapath side
  input  wire logic        uart_mode,
  input  wire logic        rx_load,
  input  wire logic [31:0] rx_word,
  input  wire logic        tx_load,
  input  wire logic        tx_busy,
  output var  logic        tx_buffer_write,
  output var  logic [31:0] tx_word,
  output var  logic        tx_stop_two,
  output var  logic        bit_order_select,
  output var  logic        double_buffer_enable,
  output var  logic        rx_buffer_full_flag,
  output var  logic        tx_buffer_empty_flag,
  output var  logic        tx_running_flag
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic logic addr_hit(input logic [31:0] addr, input logic [31:0] target);
    addr_hit = addr[sbsm_pkg::ADDR_DEC_MSB:sbsm_pkg::ADDR_WORD_LSB]
               == target[sbsm_pkg::ADDR_DEC_MSB:sbsm_pkg::ADDR_WORD_LSB];
  endfunction

  logic        access;
  logic        rd_access;
  logic        wr_access;

  assign access    = hsel && hready && (htrans == sbsm_pkg::HTRANS_NONSEQ);
  assign rd_access = access && !hwrite;
  assign wr_access = access && hwrite;

  // ----------------------------------------------------------------------
  // Data phase state
  // ----------------------------------------------------------------------
  logic        wr_pend_data;
  logic        wr_pend_mode;
  logic        next_wr_pend_data;
  logic        next_wr_pend_mode;
  logic        next_hreadyout;
  logic        next_hresp;
  logic [31:0] next_hrdata;

  // ----------------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------------
  logic        stop_two;
  logic        next_stop_two;
  logic        next_bit_order_select;
  logic        next_double_buffer_enable;
  logic        next_tx_buffer_write;
  logic [31:0] next_tx_word;
  logic        next_tx_stop_two;
  logic        order_msb;
  logic        next_order_msb;

  // ----------------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------------
  logic        status_read;
  logic        flag_tx_empty;
  logic        flag_rx_full;
  logic        flag_tx_run;
  logic [31:0] mode_word;

  assign status_read = rd_access && addr_hit(haddr, sbsm_pkg::ADDR_MODE);

  sbsm_flags u_flags (
    .core_clk    (core_clk),
    .arst_n      (arst_n),
    .rx_load     (rx_load),
    .status_read (status_read),
    .tx_write    (wr_pend_data),
    .tx_load     (tx_load),
    .tx_busy     (tx_busy),
    .tx_empty    (flag_tx_empty),
    .rx_full     (flag_rx_full),
    .tx_run      (flag_tx_run)
  );

  // Status and mode bits packed as software sees them
  always_comb begin
    mode_word                             = sbsm_pkg::RST_WORD;
    mode_word[sbsm_pkg::POS_TX_EMPTY]     = flag_tx_empty;
    mode_word[sbsm_pkg::POS_RX_FULL]      = flag_rx_full;
    mode_word[sbsm_pkg::POS_TX_RUN]       = flag_tx_run;
    mode_word[sbsm_pkg::POS_STOP_TWO]     = stop_two;
    mode_word[sbsm_pkg::POS_BIT_ORDER]    = order_msb;
    mode_word[sbsm_pkg::POS_DBUF_EN]      = double_buffer_enable;
  end

  // ----------------------------------------------------------------------
  // Bus answer: zero wait states, always OKAY
  // ----------------------------------------------------------------------
  always_comb begin
    next_hreadyout    = 1'b1;
    next_hresp        = sbsm_pkg::HRESP_OKAY;
    next_hrdata       = sbsm_pkg::RST_WORD;
    next_wr_pend_data = wr_access && addr_hit(haddr, sbsm_pkg::ADDR_DATA);
    next_wr_pend_mode = wr_access && addr_hit(haddr, sbsm_pkg::ADDR_MODE);
    if (rd_access) begin
      if (addr_hit(haddr, sbsm_pkg::ADDR_DATA)) begin
        next_hrdata = rx_word;
      end else if (addr_hit(haddr, sbsm_pkg::ADDR_MODE)) begin
        next_hrdata = mode_word;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hreadyout    <= 1'b1;
      hresp        <= sbsm_pkg::HRESP_OKAY;
      hrdata       <= sbsm_pkg::RST_WORD;
      wr_pend_data <= 1'b0;
      wr_pend_mode <= 1'b0;
    end else begin
      hreadyout    <= next_hreadyout;
      hresp        <= next_hresp;
      hrdata       <= next_hrdata;
      wr_pend_data <= next_wr_pend_data;
      wr_pend_mode <= next_wr_pend_mode;
    end
  end

  // ----------------------------------------------------------------------
  // Control register and datapath outputs
  // ----------------------------------------------------------------------
  always_comb begin
    next_stop_two             = stop_two;
    next_order_msb            = order_msb;
    next_double_buffer_enable = double_buffer_enable;
    next_tx_word              = tx_word;
    next_tx_buffer_write      = wr_pend_data;
    if (wr_pend_mode) begin
      next_stop_two             = hwdata[sbsm_pkg::POS_STOP_TWO];
      next_order_msb            = hwdata[sbsm_pkg::POS_BIT_ORDER];
      next_double_buffer_enable = hwdata[sbsm_pkg::POS_DBUF_EN];
    end
    if (wr_pend_data) begin
      next_tx_word = hwdata;
    end
    // Stop length only drives the transmitter; receive checks one stop bit
    next_tx_stop_two      = uart_mode && next_stop_two;
    // Shift direction is honoured in I/O mode only
    next_bit_order_select = !uart_mode && next_order_msb;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stop_two             <= sbsm_pkg::RST_STOP_TWO;
      order_msb            <= sbsm_pkg::RST_BIT_ORDER;
      double_buffer_enable <= sbsm_pkg::RST_DBUF_EN;
      tx_word              <= sbsm_pkg::RST_WORD;
      tx_buffer_write      <= 1'b0;
      tx_stop_two          <= sbsm_pkg::RST_STOP_TWO;
      bit_order_select     <= sbsm_pkg::RST_BIT_ORDER;
    end else begin
      stop_two             <= next_stop_two;
      order_msb            <= next_order_msb;
      double_buffer_enable <= next_double_buffer_enable;
      tx_word              <= next_tx_word;
      tx_buffer_write      <= next_tx_buffer_write;
      tx_stop_two          <= next_tx_stop_two;
      bit_order_select     <= next_bit_order_select;
    end
  end

  // ----------------------------------------------------------------------
  // Flag outputs, registered copies of the flag unit
  // ----------------------------------------------------------------------
  // Flags run regardless of the enable; software ignores them when it is off
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_buffer_full_flag  <= sbsm_pkg::RST_RX_FULL;
      tx_buffer_empty_flag <= sbsm_pkg::RST_TX_EMPTY;
      tx_running_flag      <= sbsm_pkg::RST_TX_RUN;
    end else begin
      rx_buffer_full_flag  <= flag_rx_full;
      tx_buffer_empty_flag <= flag_tx_empty;
      tx_running_flag      <= flag_tx_run;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  stop_len_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    wr_pend_mode && uart_mode |=> tx_stop_two == $past(hwdata[sbsm_pkg::POS_STOP_TWO]))
    else $error("stop length not taken from mode write");

  order_uart_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    uart_mode |=> !bit_order_select)
    else $error("bit order not LSB first in UART mode");

  dbuf_write_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    wr_access && addr_hit(haddr, sbsm_pkg::ADDR_MODE)
      ##1 1'b1 |=> double_buffer_enable == $past(hwdata[sbsm_pkg::POS_DBUF_EN]))
    else $error("double buffer enable not written");

  read_clear_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    status_read && !rx_load |=> ##1 !rx_buffer_full_flag)
    else $error("status read does not clear rx full output");

  tx_write_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    wr_access && addr_hit(haddr, sbsm_pkg::ADDR_DATA) |=> ##1 tx_buffer_write && tx_word == $past(hwdata))
    else $error("transmit buffer write not passed on");

  // ----------------------------------------------------------------------
  // Checks on what software and the datapath see
  // ----------------------------------------------------------------------
  run_on_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    tx_busy |=> ##1 tx_running_flag)
    else $error("running output not set while transmitting");

  run_off_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !tx_busy |=> ##1 !tx_running_flag)
    else $error("running output not cleared when stopped");

  full_out_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    rx_load |=> ##1 rx_buffer_full_flag)
    else $error("rx full output not set after receive load");

  empty_out_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    tx_load |=> ##1 tx_buffer_empty_flag)
    else $error("tx empty output not set after shift load");

  empty_clear_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    wr_pend_data && !tx_load |=> ##1 !tx_buffer_empty_flag)
    else $error("tx empty output not cleared by buffer write");

  status_view_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    rd_access && addr_hit(haddr, sbsm_pkg::ADDR_MODE)
      |=> hrdata[sbsm_pkg::POS_TX_RUN] == $past(flag_tx_run)
          && hrdata[sbsm_pkg::POS_TX_EMPTY] == $past(flag_tx_empty))
    else $error("status read does not show running and empty flags");

  full_view_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    status_read |=> hrdata[sbsm_pkg::POS_RX_FULL] == $past(flag_rx_full))
    else $error("status read does not show rx full flag");

  data_read_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    rd_access && addr_hit(haddr, sbsm_pkg::ADDR_DATA) |=> hrdata == $past(rx_word))
    else $error("data read does not return receive buffer");

  stop_gate_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !uart_mode |=> !tx_stop_two)
    else $error("stop length applied outside UART mode");

  stop_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !wr_pend_mode && $stable(uart_mode) |=> $stable(tx_stop_two))
    else $error("stop length changed without mode write");

  order_io_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    wr_pend_mode && !uart_mode |=> bit_order_select == $past(hwdata[sbsm_pkg::POS_BIT_ORDER]))
    else $error("bit order not taken from mode write");

  order_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !wr_pend_mode && $stable(uart_mode) |=> $stable(bit_order_select))
    else $error("bit order changed without mode write");

  dbuf_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !wr_pend_mode |=> $stable(double_buffer_enable))
    else $error("double buffer enable changed without mode write");

  word_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !wr_pend_data |=> $stable(tx_word) && !tx_buffer_write)
    else $error("transmit buffer changed without data write");

endmodule

`default_nettype wire

// ---- sbsm_far_end.sv ----
/*
  Far-side model of the serial channel datapath: the transmit shifter that
  empties the tx buffer and the receive shifter that delivers words.
  Assumes the status block and the bench share core_clk with this model.
*/
`timescale 1ns/1ps
`default_nettype none

module sbsm_far_end (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        tx_buffer_write,
  input  wire logic [7:0]  start_delay,
  input  wire logic [7:0]  busy_len,
  input  wire logic        rx_kick,
  input  wire logic [31:0] rx_value,
  output var  logic        rx_load,
  output var  logic [31:0] rx_word,
  output var  logic        tx_load,
  output var  logic        tx_busy
);
  logic       pend;
  logic [7:0] wait_cnt;
  logic [7:0] busy_cnt;

  assign tx_busy = (busy_cnt != 8'h00);

  // ----------------------------------------------------------------------
  // Shifters
  // ----------------------------------------------------------------------
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend     <= 1'b0;
      wait_cnt <= 8'h00;
      busy_cnt <= 8'h00;
      tx_load  <= 1'b0;
      rx_load  <= 1'b0;
      rx_word  <= 32'hffff_ffff;
    end else begin
      rx_load <= rx_kick;
      if (rx_kick) begin
        rx_word <= rx_value;
      end
      tx_load <= 1'b0;
      if (busy_cnt != 8'h00) begin
        busy_cnt <= busy_cnt - 8'h01;
      end
      if (tx_buffer_write) begin
        pend     <= 1'b1;
        wait_cnt <= start_delay;
      end else if (pend && wait_cnt != 8'h00) begin
        wait_cnt <= wait_cnt - 8'h01;
      end else if (pend && busy_cnt <= 8'h01) begin
        // Shifter free: take the held word
        tx_load  <= 1'b1;
        pend     <= 1'b0;
        busy_cnt <= busy_len;
      end
    end
  end
endmodule

`default_nettype wire

// ---- serial_buffer_status_mode_test.sv ----
/*
  Self-checking bench for the serial buffer status and mode block.
  Assumes sbsm_pkg, sbsm_top and the far-side model sbsm_far_end.
*/
`timescale 1ns/1ps
`default_nettype none

module serial_buffer_status_mode_test;
  typedef struct packed {
    logic       uart;
    logic [2:0] bits;
    logic [2:0] exp;
  } sbsm_row_type;

  logic         core_clk = 1'b0;
  logic         arst_n   = 1'b0;
  logic         hsel     = 1'b0;
  logic [31:0]  haddr    = 32'h0;
  logic [1:0]   htrans   = 2'h0;
  logic         hwrite   = 1'b0;
  logic [2:0]   hsize    = 3'h2;
  logic [31:0]  hwdata   = 32'h0;
  logic         uart_mode = 1'b1;
  logic         rx_kick  = 1'b0;
  logic [31:0]  rx_value = 32'h0;
  logic [7:0]   start_delay = 8'h06;
  logic [7:0]   busy_len = 8'h0a;
  wire logic    hreadyout;
  wire logic    hresp;
  wire logic [31:0] hrdata;
  wire logic    rx_load;
  wire logic [31:0] rx_word;
  wire logic    tx_load;
  wire logic    tx_busy;
  wire logic    tx_buffer_write;
  wire logic [31:0] tx_word;
  wire logic    tx_stop_two;
  wire logic    bit_order_select;
  wire logic    double_buffer_enable;
  wire logic    rx_buffer_full_flag;
  wire logic    tx_buffer_empty_flag;
  wire logic    tx_running_flag;
  logic [31:0]  rd;
  int           mismatches = 0;
  int           cmp_count = 0;
  int           cyc_count = 0;
  int           n;
  // Uart rows keep LSB first
  sbsm_row_type rows [5] = '{'{1'b1, 3'b001, 3'b001}, '{1'b1, 3'b100, 3'b100},
    '{1'b0, 3'b010, 3'b010}, '{1'b0, 3'b110, 3'b010}, '{1'b0, 3'b101, 3'b001}};

  always #25 core_clk = ~core_clk;

  sbsm_top u_dut (.core_clk(core_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .uart_mode(uart_mode), .rx_load(rx_load), .rx_word(rx_word),
    .tx_load(tx_load), .tx_busy(tx_busy), .tx_buffer_write(tx_buffer_write), .tx_word(tx_word),
    .tx_stop_two(tx_stop_two), .bit_order_select(bit_order_select),
    .double_buffer_enable(double_buffer_enable), .rx_buffer_full_flag(rx_buffer_full_flag),
    .tx_buffer_empty_flag(tx_buffer_empty_flag), .tx_running_flag(tx_running_flag));

  sbsm_far_end u_far (.core_clk(core_clk), .arst_n(arst_n), .tx_buffer_write(tx_buffer_write),
    .start_delay(start_delay), .busy_len(busy_len), .rx_kick(rx_kick), .rx_value(rx_value),
    .rx_load(rx_load), .rx_word(rx_word), .tx_load(tx_load), .tx_busy(tx_busy));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic ahb_xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
    int k;
    hsel   <= 1'b1;
    haddr  <= addr;
    htrans <= sbsm_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    if (wr) begin
      hwdata <= wdata;
    end
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    rd = hrdata;
    check(32'(hresp), 32'(sbsm_pkg::HRESP_OKAY));
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc_count++;
    if (cyc_count == 3000) begin
      mismatches++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    check(32'({tx_buffer_empty_flag, rx_buffer_full_flag, tx_running_flag}), 32'h4);
    ahb_xfer(1'b0, sbsm_pkg::ADDR_MODE, 32'h0);
    check(rd, 32'h0000_0080);
    ahb_xfer(1'b0, 32'h0000_0010, 32'h0);
    check(rd, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      uart_mode <= rows[i].uart;
      ahb_xfer(1'b1, sbsm_pkg::ADDR_MODE, 32'({rows[i].bits, 2'h0}));
      repeat (2) @(posedge core_clk);
      check(32'({tx_stop_two, bit_order_select, double_buffer_enable}), 32'(rows[i].exp));
      ahb_xfer(1'b0, sbsm_pkg::ADDR_MODE, 32'h0);
      check(32'(rd[4:2]), 32'(rows[i].bits));
    end
    $display("test mode rows done");
    uart_mode <= 1'b1;
    ahb_xfer(1'b1, sbsm_pkg::ADDR_MODE, 32'h0000_0004);
    rx_value <= 32'h0000_a5c3;
    rx_kick  <= 1'b1;
    @(posedge core_clk);
    rx_kick <= 1'b0;
    repeat (3) @(posedge core_clk);
    check(32'(rx_buffer_full_flag), 32'h1);
    ahb_xfer(1'b0, sbsm_pkg::ADDR_DATA, 32'h0);
    check(rd, 32'h0000_a5c3);
    ahb_xfer(1'b0, sbsm_pkg::ADDR_MODE, 32'h0);
    check(32'(rd[6]), 32'h1);
    repeat (3) @(posedge core_clk);
    check(32'(rx_buffer_full_flag), 32'h0);
    ahb_xfer(1'b0, sbsm_pkg::ADDR_MODE, 32'h0);
    check(32'(rd[6]), 32'h0);
    $display("test receive done");
    ahb_xfer(1'b1, sbsm_pkg::ADDR_DATA, 32'h1234_5678);
    @(posedge core_clk);
    check(32'(tx_buffer_write), 32'h1);
    @(posedge core_clk);
    check(tx_word, 32'h1234_5678);
    check(32'({tx_running_flag, tx_buffer_empty_flag}), 32'h0);
    for (n = 0; n < 40 && tx_running_flag !== 1'b1; n++) @(posedge core_clk);
    @(posedge core_clk);
    check(32'({tx_running_flag, tx_buffer_empty_flag}), 32'h3);
    for (n = 0; n < 40 && tx_running_flag !== 1'b0; n++) @(posedge core_clk);
    repeat (2) @(posedge core_clk);
    check(32'({tx_running_flag, tx_buffer_empty_flag}), 32'h1);
    $display("test slow transmit done");
    start_delay <= 8'h00;
    ahb_xfer(1'b1, sbsm_pkg::ADDR_DATA, 32'h0000_00c1);
    repeat (4) @(posedge core_clk);
    ahb_xfer(1'b1, sbsm_pkg::ADDR_DATA, 32'h0000_00c2);
    repeat (3) @(posedge core_clk);
    check(32'({tx_running_flag, tx_buffer_empty_flag}), 32'h2);
    for (n = 0; n < 40 && tx_buffer_empty_flag !== 1'b1; n++) @(posedge core_clk);
    check(32'({tx_running_flag, tx_buffer_empty_flag}), 32'h3);
    $display("test back to back transmit done");
    // Receive load meets a status read in one cycle
    rx_value <= 32'h0000_3c5a;
    rx_kick  <= 1'b1;
    @(posedge core_clk);
    rx_kick <= 1'b0;
    ahb_xfer(1'b0, sbsm_pkg::ADDR_MODE, 32'h0);
    repeat (2) @(posedge core_clk);
    check(32'(rx_buffer_full_flag), 32'h1);
    $display("test set wins over read clear done");
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    check(32'({tx_buffer_empty_flag, rx_buffer_full_flag, tx_running_flag}), 32'h4);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    check(32'({tx_stop_two, bit_order_select, double_buffer_enable}), 32'h0);
    check(tx_word, 32'h0);
    ahb_xfer(1'b0, sbsm_pkg::ADDR_MODE, 32'h0);
    check(rd, 32'h0000_0080);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule

`default_nettype wire
